/* File: core/ode_pkg.sv */
// Constants, register map and carrier types of the output disable unit.
// Assumes a 32-bit APB master and a timer that drives pin values and enables.
package ode_pkg;

   // Fault inputs zero to three and eight, index 4 is input eight
   localparam int NFLT  = 5;
   localparam int ST_W  = 9;
   localparam int CFG_W = 13;
   localparam int AW    = 12;

   // Register byte offsets
   localparam logic [AW-1:0] CFG_OFF    = 12'h000;
   localparam logic [AW-1:0] CH0SEL_OFF = 12'h004;
   localparam logic [AW-1:0] STATUS_OFF = 12'h008;
   localparam logic [AW-1:0] MASK_OFF   = 12'h00C;
   localparam logic [AW-1:0] SWREQ_OFF  = 12'h010;
   localparam logic [AW-1:0] PIN_OFF    = 12'h014;

   // Status, mask and channel-zero select share this layout
   localparam int ST_IN0      = 0;
   localparam int ST_IN8      = 4;
   localparam int ST_CONFLICT = 5;
   localparam int ST_OSC      = 6;
   localparam int ST_SW       = 7;
   localparam int ST_EVT      = 8;

   // Configuration fields
   localparam int CFG_MODE_LSB    = 0;
   localparam int CFG_CONFLICT_EN = 10;
   localparam int CFG_OSC_EN      = 11;
   localparam int CFG_EVT_EN      = 12;

   // Per-input detection modes, two bits each
   localparam logic [1:0] MODE_FALL = 2'h0;
   localparam logic [1:0] MODE_RISE = 2'h1;
   localparam logic [1:0] MODE_LOW  = 2'h2;
   localparam logic [1:0] MODE_OFF  = 2'h3;

   // Other register fields
   localparam int SWREQ_BIT   = 0;
   localparam int PIN_PWM_HIZ = 0;
   localparam int PIN_CH0_HIZ = 1;
   localparam int PIN_LVL_LSB = 4;

   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST    = 13'h03FF;
   localparam logic [ST_W-1:0]  CH0SEL_RST = 9'h040;
   localparam logic [ST_W-1:0]  MASK_RST   = 9'h000;
   localparam logic [ST_W-1:0]  STATUS_RST = 9'h000;

   // Complementary PWM pin order within the pwm vector
   localparam int PWM_3B = 0;
   localparam int PWM_3D = 1;
   localparam int PWM_4A = 2;
   localparam int PWM_4B = 3;
   localparam int PWM_4C = 4;
   localparam int PWM_4D = 5;

   typedef struct packed {
      logic [5:0] pwm;
      logic [3:0] ch0;
   } ode_pins_t;

   localparam ode_pins_t PINS_RST = '0;

   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      logic [ST_W-1:0]  ch0sel;
      logic [ST_W-1:0]  status;
      logic [ST_W-1:0]  mask;
      logic [31:0]      prdata;
      logic             slverr;
      ode_pins_t        pin_out;
      ode_pins_t        pin_oe;
   } ode_state_t;

endpackage

/* File: core/ode_sync_edge.sv */
// Two-flop synchroniser with registered edge pulses for a vector of levels.
// Inputs may come from any domain; outputs are on pclk.
`timescale 1ns/1ps
module ode_sync_edge #(
   parameter int           W    = 5,
   parameter logic [W-1:0] IDLE = '1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] fall,
   output logic      [W-1:0] rise
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
      logic [W-1:0] fall;
      logic [W-1:0] rise;
   } ode_se_t;

   ode_se_t st;
   ode_se_t next_st;

   always_comb begin
      next_st      = st;
      next_st.meta = async_in;
      // Only the second stage reads the first
      next_st.sync = st.meta;
      next_st.prev = st.sync;
      next_st.fall = st.prev & ~st.sync;
      next_st.rise = ~st.prev & st.sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{meta: IDLE, sync: IDLE, prev: IDLE, fall: '0, rise: '0};
      end else begin
         st <= next_st;
      end
   end

   assign level = st.sync;
   assign fall  = st.fall;
   assign rise  = st.rise;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_one_fall_pulse: assert property ((fall != '0) |=> ((fall & $past(fall)) == '0))
      else $error("fall pulse lasted two cycles");

   // The pulse is one edge behind the synchronised level that it reports
   chk_fall_follows_sync: assert property ((fall != '0)
                                           |-> ((fall & $past(level, 2) & ~$past(level)) == fall))
      else $error("fall pulse without a synchronised edge");

endmodule

/* File: core/ode_top.sv */
// Output disable unit: floats PWM and channel-zero timer pins on faults.
// Assumes an APB3 master on pclk and a timer whose pin drive arrives on pclk.
//
// Functional notes
// - Fault input edge or level floats controlled pins
// - Conflicting complementary PWM levels float the pins
// - Oscillation stop floats the controlled pins
// - Software request register floats the pins
// - Event link signal floats the pins
// - Input zero falling edge floats PWM, interrupts
// - Oscillation stop floats channel zero and PWM
// - Sticky clearable flag per input and oscillation
// - Pins stay floated until flags are cleared
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ode_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [ode_pkg::AW-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [ode_pkg::NFLT-1:0] fault_input_n,
   input  wire logic                   osc_stop,
   input  wire logic                   event_link_evt,
   input  wire ode_pkg::ode_pins_t     tmr_out,
   input  wire ode_pkg::ode_pins_t     tmr_oe,
   output ode_pkg::ode_pins_t          pin_out,
   output ode_pkg::ode_pins_t          pin_oe,
   output logic                        pwm_hiz,
   output logic                        ch0_hiz,
   output logic                        irq
);

   ode_pkg::ode_state_t st;
   ode_pkg::ode_state_t next_st;

   logic [ode_pkg::NFLT-1:0] flt_lvl;
   logic [ode_pkg::NFLT-1:0] flt_fall;
   logic [ode_pkg::NFLT-1:0] flt_rise;
   logic [ode_pkg::NFLT-1:0] fault_det;
   logic [0:0]               osc_lvl;
   logic                     conflict;
   logic                     wr;
   logic                     setup;
   logic                     mapped;
   logic [ode_pkg::ST_W-1:0] set_ev;
   logic [ode_pkg::ST_W-1:0] clr;
   logic                     pwm_float;
   logic                     ch0_float;

   function automatic logic hit(input logic [ode_pkg::AW-1:0] a, input logic [ode_pkg::AW-1:0] off);
      return a == off;
   endfunction

   function automatic logic fault_hit(input logic [1:0] mode, input logic f, input logic r, input logic lv);
      logic h;
      h = 1'b0;
      case (mode)
         ode_pkg::MODE_FALL: h = f;
         ode_pkg::MODE_RISE: h = r;
         ode_pkg::MODE_LOW:  h = ~lv;
         default:            h = 1'b0;
      endcase
      return h;
   endfunction

   // Fault pins are active low and idle high
   ode_sync_edge #(
      .W    (ode_pkg::NFLT),
      .IDLE ({ode_pkg::NFLT{1'b1}})
   ) u_flt_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (fault_input_n),
      .level    (flt_lvl),
      .fall     (flt_fall),
      .rise     (flt_rise)
   );

   // The stop indication comes from the clock generator's own timing
   ode_sync_edge #(
      .W    (1),
      .IDLE (1'b0)
   ) u_osc_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (osc_stop),
      .level    (osc_lvl),
      .fall     (),
      .rise     ()
   );

   genvar gi;
   for (gi = 0; gi < ode_pkg::NFLT; gi++) begin : g_det
      assign fault_det[gi] = fault_hit(st.cfg[ode_pkg::CFG_MODE_LSB + 2*gi +: 2],
                                       flt_fall[gi], flt_rise[gi], flt_lvl[gi]);
   end

   // Both halves of a complementary pair driven high at once
   assign conflict = (tmr_oe.pwm[ode_pkg::PWM_3B] & tmr_oe.pwm[ode_pkg::PWM_3D] &
                      tmr_out.pwm[ode_pkg::PWM_3B] & tmr_out.pwm[ode_pkg::PWM_3D]) |
                     (tmr_oe.pwm[ode_pkg::PWM_4A] & tmr_oe.pwm[ode_pkg::PWM_4C] &
                      tmr_out.pwm[ode_pkg::PWM_4A] & tmr_out.pwm[ode_pkg::PWM_4C]) |
                     (tmr_oe.pwm[ode_pkg::PWM_4B] & tmr_oe.pwm[ode_pkg::PWM_4D] &
                      tmr_out.pwm[ode_pkg::PWM_4B] & tmr_out.pwm[ode_pkg::PWM_4D]);

   always_comb begin
      next_st = st;
      wr      = psel & penable & pwrite;
      setup   = psel & ~penable;
      mapped  = hit(paddr, ode_pkg::CFG_OFF) | hit(paddr, ode_pkg::CH0SEL_OFF) |
                hit(paddr, ode_pkg::STATUS_OFF) | hit(paddr, ode_pkg::MASK_OFF) |
                hit(paddr, ode_pkg::SWREQ_OFF) | hit(paddr, ode_pkg::PIN_OFF);

      // Event sources
      set_ev = '0;
      set_ev[ode_pkg::ST_IN8:ode_pkg::ST_IN0] = fault_det;
      set_ev[ode_pkg::ST_CONFLICT] = conflict & st.cfg[ode_pkg::CFG_CONFLICT_EN];
      set_ev[ode_pkg::ST_OSC] = osc_lvl[0] & st.cfg[ode_pkg::CFG_OSC_EN];
      set_ev[ode_pkg::ST_SW] = wr & hit(paddr, ode_pkg::SWREQ_OFF) & pwdata[ode_pkg::SWREQ_BIT];
      set_ev[ode_pkg::ST_EVT] = event_link_evt & st.cfg[ode_pkg::CFG_EVT_EN];

      clr = '0;
      if (wr && hit(paddr, ode_pkg::STATUS_OFF)) begin
         clr = pwdata[ode_pkg::ST_W-1:0];
      end

      // A new event beats a clear in the same cycle
      next_st.status = (st.status & ~clr) | set_ev;

      if (wr && hit(paddr, ode_pkg::CFG_OFF)) begin
         next_st.cfg = pwdata[ode_pkg::CFG_W-1:0];
      end
      if (wr && hit(paddr, ode_pkg::CH0SEL_OFF)) begin
         next_st.ch0sel = pwdata[ode_pkg::ST_W-1:0];
      end
      if (wr && hit(paddr, ode_pkg::MASK_OFF)) begin
         next_st.mask = pwdata[ode_pkg::ST_W-1:0];
      end

      // Read data is captured in the setup cycle so it stands through access
      if (setup) begin
         next_st.slverr = ~mapped;
         next_st.prdata = '0;
         if (hit(paddr, ode_pkg::CFG_OFF)) begin
            next_st.prdata = 32'(st.cfg);
         end else if (hit(paddr, ode_pkg::CH0SEL_OFF)) begin
            next_st.prdata = 32'(st.ch0sel);
         end else if (hit(paddr, ode_pkg::STATUS_OFF)) begin
            next_st.prdata = 32'(st.status);
         end else if (hit(paddr, ode_pkg::MASK_OFF)) begin
            next_st.prdata = 32'(st.mask);
         end else if (hit(paddr, ode_pkg::SWREQ_OFF)) begin
            next_st.prdata = 32'(st.status[ode_pkg::ST_SW]);
         end else if (hit(paddr, ode_pkg::PIN_OFF)) begin
            next_st.prdata[ode_pkg::PIN_PWM_HIZ] = |st.status;
            next_st.prdata[ode_pkg::PIN_CH0_HIZ] = |(st.status & st.ch0sel);
            next_st.prdata[ode_pkg::PIN_LVL_LSB +: ode_pkg::NFLT] = flt_lvl;
         end
      end else if (!psel) begin
         next_st.slverr = 1'b0;
         next_st.prdata = '0;
      end

      // Floating follows the flags of the same edge, so no pin leaks a cycle
      pwm_float = |next_st.status;
      ch0_float = |(next_st.status & next_st.ch0sel);
      next_st.pin_out = tmr_out;
      next_st.pin_oe.pwm = pwm_float ? 6'h00 : tmr_oe.pwm;
      next_st.pin_oe.ch0 = ch0_float ? 4'h0 : tmr_oe.ch0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{cfg:     ode_pkg::CFG_RST,
                 ch0sel:  ode_pkg::CH0SEL_RST,
                 status:  ode_pkg::STATUS_RST,
                 mask:    ode_pkg::MASK_RST,
                 prdata:  32'h0000_0000,
                 slverr:  1'b0,
                 pin_out: ode_pkg::PINS_RST,
                 pin_oe:  ode_pkg::PINS_RST};
      end else begin
         st <= next_st;
      end
   end

   // Zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign prdata  = st.prdata;
   assign pslverr = st.slverr;
   assign pin_out = st.pin_out;
   assign pin_oe  = st.pin_oe;
   assign pwm_hiz = |st.status;
   assign ch0_hiz = |(st.status & st.ch0sel);
   assign irq     = |(st.status & st.mask);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_in0_fall;
      (st.cfg[1:0] == ode_pkg::MODE_FALL) && flt_fall[0];
   endsequence

   sequence s_sw_write;
      psel && penable && pwrite && (paddr == ode_pkg::SWREQ_OFF) && pwdata[ode_pkg::SWREQ_BIT];
   endsequence

   sequence s_no_clear;
      !(psel && penable && pwrite && (paddr == ode_pkg::STATUS_OFF));
   endsequence

   chk_in0_fall_float: assert property (s_in0_fall |=> st.status[ode_pkg::ST_IN0] && (pin_oe.pwm == 6'h00))
      else $error("input zero fall did not float the PWM pins");

   chk_in0_irq: assert property (s_in0_fall ##1 st.mask[ode_pkg::ST_IN0] |-> irq)
      else $error("input zero fall raised no interrupt");

   chk_fault_any: assert property ((fault_det != '0) |=> pwm_hiz && (pin_oe.pwm == 6'h00))
      else $error("fault input did not float the PWM pins");

   chk_conflict_flag: assert property (conflict && st.cfg[ode_pkg::CFG_CONFLICT_EN]
                                       |=> st.status[ode_pkg::ST_CONFLICT])
      else $error("PWM level conflict not flagged");

   chk_osc_flag: assert property (osc_lvl[0] && st.cfg[ode_pkg::CFG_OSC_EN] |=> st.status[ode_pkg::ST_OSC])
      else $error("oscillation stop not flagged");

   chk_osc_ch0_pins: assert property (st.status[ode_pkg::ST_OSC] && st.ch0sel[ode_pkg::ST_OSC]
                                      |-> (pin_oe.ch0 == 4'h0) && (pin_oe.pwm == 6'h00))
      else $error("oscillation stop left pins driven");

   chk_sw_request: assert property (s_sw_write |=> st.status[ode_pkg::ST_SW] && pwm_hiz)
      else $error("software request did not float pins");

   chk_event_link: assert property (event_link_evt && st.cfg[ode_pkg::CFG_EVT_EN]
                                    |=> st.status[ode_pkg::ST_EVT])
      else $error("event link signal not flagged");

   chk_flag_sticky: assert property ((st.status[ode_pkg::ST_IN0] and s_no_clear)
                                     |=> st.status[ode_pkg::ST_IN0])
      else $error("detection flag dropped without a clear");

   chk_release_pins: assert property (st.status == '0 ##1 st.status == '0
                                      |-> (pin_oe == $past(tmr_oe)) && (pin_out == $past(tmr_out)))
      else $error("pins not returned to timer control");

   chk_read_answer: assert property (psel && !penable |=> pready && (pslverr == !$past(mapped)))
      else $error("APB answer wrong");

endmodule

/* File: verif/ode_far_side.sv */
// Far-side model: fault pins, oscillation monitor, event link and timer drive.
// Assumes the bench calls its tasks from one process; changes land just after pclk.
`timescale 1ns/1ps
module ode_far_side (
   input  wire logic                     pclk,
   output logic      [ode_pkg::NFLT-1:0] fault_input_n,
   output logic                          osc_stop,
   output logic                          event_link_evt,
   output ode_pkg::ode_pins_t            tmr_out,
   output ode_pkg::ode_pins_t            tmr_oe
);
   initial begin
      fault_input_n = '1;
      osc_stop = 1'b0;
      event_link_evt = 1'b0;
      tmr_out = '0;
      tmr_oe = '1;
   end
   // Asynchronous to the block in reality; the synchroniser must cope either way
   task automatic set_fault(input int i, input logic v);
      @(posedge pclk);
      fault_input_n[i] <= v;
   endtask
   task automatic set_osc(input logic v);
      @(posedge pclk);
      osc_stop <= v;
   endtask
   task automatic pulse_evt();
      @(posedge pclk);
      event_link_evt <= 1'b1;
      @(posedge pclk);
      event_link_evt <= 1'b0;
   endtask
   task automatic set_drive(input ode_pkg::ode_pins_t v);
      @(posedge pclk);
      tmr_out <= v;
   endtask
endmodule

/* File: verif/ode_top_bench.sv */
// Self-checking bench for the output disable unit, registers reached over APB.
// Assumes zero-wait APB answers are possible but never relies on them.
`timescale 1ns/1ps
module ode_top_bench;
   logic               pclk;
   logic               presetn;
   logic [11:0]        paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [4:0]         fault_input_n;
   logic               osc_stop;
   logic               event_link_evt;
   ode_pkg::ode_pins_t tmr_out;
   ode_pkg::ode_pins_t tmr_oe;
   ode_pkg::ode_pins_t pin_out;
   ode_pkg::ode_pins_t pin_oe;
   logic               pwm_hiz;
   logic               ch0_hiz;
   logic               irq;
   logic [31:0]        rd_q;
   logic               err_q;
   int                 num_errors;
   int                 tests_run;

   ode_top u_ode_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_input_n(fault_input_n), .osc_stop(osc_stop), .event_link_evt(event_link_evt),
      .tmr_out(tmr_out), .tmr_oe(tmr_oe), .pin_out(pin_out), .pin_oe(pin_oe),
      .pwm_hiz(pwm_hiz), .ch0_hiz(ch0_hiz), .irq(irq));
   ode_far_side u_ode_far_side (.pclk(pclk), .fault_input_n(fault_input_n), .osc_stop(osc_stop),
      .event_link_evt(event_link_evt), .tmr_out(tmr_out), .tmr_oe(tmr_oe));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Samples read data at the completing edge without racing the register update
   always @(posedge pclk) begin
      rd_q <= prdata;
      err_q <= pslverr;
   end

   task automatic chk(input string m, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %s: got %h expected %h", $time, m, g, e);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] d, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      d = rd_q;
      e = err_q;
      chk("apb answer", 32'h1, {31'h0, n < 50});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      apb(a, 1'b1, wd, d, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] d;
      logic        e;
      apb(a, 1'b0, 32'h0, d, e);
      chk("read data", x, d);
   endtask
   // Completion is the float flag; bounded so a dead source cannot hang the run
   task automatic wait_hiz();
      int n;
      n = 0;
      while (pwm_hiz !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      #1;
      chk("float flag", 32'h1, {31'h0, pwm_hiz});
   endtask
   task automatic clear_all();
      repeat (6) @(posedge pclk);
      wr(ode_pkg::STATUS_OFF, 32'h0000_01FF);
   endtask
   task automatic done(input string m);
      $display("test %s done", m);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      logic        e;
      num_errors = 0;
      tests_run = 0;
      presetn = 1'b0;
      paddr = '0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(ode_pkg::CFG_OFF, 32'h0000_03FF);
      rd(ode_pkg::CH0SEL_OFF, 32'h0000_0040);
      rd(ode_pkg::STATUS_OFF, 32'h0);
      rd(ode_pkg::MASK_OFF, 32'h0);
      apb(12'h018, 1'b0, 32'h0, d, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
      done("reset");
      wr(ode_pkg::CFG_OFF, 32'h0000_03FC);
      wr(ode_pkg::MASK_OFF, 32'h0000_0001);
      u_ode_far_side.set_fault(0, 1'b0);
      wait_hiz();
      chk("irq raised", 32'h1, {31'h0, irq});
      chk("pwm floated", 32'h0000_000F, {22'h0, pin_oe});
      rd(ode_pkg::STATUS_OFF, 32'h0000_0001);
      u_ode_far_side.set_fault(0, 1'b1);
      clear_all();
      chk("released", 32'h0000_03FF, {22'h0, pin_oe});
      chk("irq cleared", 32'h0, {31'h0, irq});
      repeat (8) @(posedge pclk);
      rd(ode_pkg::STATUS_OFF, 32'h0);
      done("input zero");
      wr(ode_pkg::CFG_OFF, 32'h0);
      for (int i = 1; i < 5; i++) begin
         u_ode_far_side.set_fault(i, 1'b0);
         wait_hiz();
         rd(ode_pkg::STATUS_OFF, 32'h1 << i);
         chk("irq masked", 32'h0, {31'h0, irq});
         u_ode_far_side.set_fault(i, 1'b1);
         clear_all();
      end
      done("inputs");
      wr(ode_pkg::CFG_OFF, 32'h0000_0BFF);
      u_ode_far_side.set_osc(1'b1);
      wait_hiz();
      chk("all floated", 32'h0, {22'h0, pin_oe});
      chk("ch0 flag", 32'h1, {31'h0, ch0_hiz});
      rd(ode_pkg::PIN_OFF, 32'h0000_01F3);
      u_ode_far_side.set_osc(1'b0);
      clear_all();
      rd(ode_pkg::STATUS_OFF, 32'h0);
      done("osc stop");
      wr(ode_pkg::SWREQ_OFF, 32'h0000_0001);
      wait_hiz();
      rd(ode_pkg::STATUS_OFF, 32'h0000_0080);
      chk("ch0 kept", 32'h0, {31'h0, ch0_hiz});
      clear_all();
      done("software");
      wr(ode_pkg::CFG_OFF, 32'h0000_13FF);
      u_ode_far_side.pulse_evt();
      wait_hiz();
      rd(ode_pkg::STATUS_OFF, 32'h0000_0100);
      clear_all();
      done("event");
      wr(ode_pkg::CFG_OFF, 32'h0000_07FF);
      u_ode_far_side.set_drive(10'h030);
      wait_hiz();
      rd(ode_pkg::STATUS_OFF, 32'h0000_0020);
      chk("pin drive", 32'h0000_0030, {22'h0, pin_out});
      chk("conflict float", 32'h0000_000F, {22'h0, pin_oe});
      u_ode_far_side.set_drive(10'h000);
      clear_all();
      rd(ode_pkg::STATUS_OFF, 32'h0);
      done("conflict");
      // Input zero on low level, input one on rising edge
      wr(ode_pkg::CFG_OFF, 32'h0000_03F6);
      u_ode_far_side.set_fault(0, 1'b0);
      wait_hiz();
      wr(ode_pkg::STATUS_OFF, 32'h0000_0001);
      rd(ode_pkg::STATUS_OFF, 32'h0000_0001);
      u_ode_far_side.set_fault(0, 1'b1);
      clear_all();
      u_ode_far_side.set_fault(1, 1'b0);
      repeat (6) @(posedge pclk);
      rd(ode_pkg::STATUS_OFF, 32'h0);
      u_ode_far_side.set_fault(1, 1'b1);
      wait_hiz();
      rd(ode_pkg::STATUS_OFF, 32'h0000_0002);
      clear_all();
      rd(ode_pkg::STATUS_OFF, 32'h0);
      done("modes");
      finish_test();
   end

   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
endmodule
